// ==== rtl/pms_pkg.sv ====
package pms_pkg;
  // ==========================================================
  // Clock rates in kHz
  localparam int CLK_KHZ = 200000;
  localparam int RXC_KHZ_10 = 2500;
  localparam int RXC_KHZ_100 = 25000;
  localparam int RXC_KHZ_1000 = 125000;
  localparam int TXC_KHZ = 125000;
  localparam int SERC_KHZ = 625000;
  // ==========================================================
  // Widths and layout
  localparam int NIB_W = 4;
  localparam int BYTE_W = 8;
  localparam int WORD_W = BYTE_W + 1;
  localparam int FIFO_DEPTH = 16;
  localparam int HALF_W = 8;
  localparam int SER_BITS = WORD_W + 1;
  localparam int SER_CNT_W = 4;
  localparam int SY_W = 8;
  localparam int SY_PCLK = 7;
  localparam int SY_PCTL = 6;
  localparam int SY_NIB = 2;
  localparam int SY_SCLK = 1;
  localparam int SY_SDAT = 0;
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  // Half period in clk cycles, never below one
  function automatic logic [HALF_W-1:0] half_cycles(input int khz);
    int n;
    n = CLK_KHZ / (2 * khz);
    half_cycles = HALF_W'((n < 1) ? 1 : n);
  endfunction
  localparam logic [HALF_W-1:0] HALF_10 = half_cycles(RXC_KHZ_10);
  localparam logic [HALF_W-1:0] HALF_100 = half_cycles(RXC_KHZ_100);
  localparam logic [HALF_W-1:0] HALF_1000 = half_cycles(RXC_KHZ_1000);
  localparam logic [HALF_W-1:0] HALF_TX = half_cycles(TXC_KHZ);
  localparam logic [HALF_W-1:0] HALF_SER = half_cycles(SERC_KHZ);
  typedef enum logic {SR_IDLE, SR_SHIFT} pms_ser_state_type;
  typedef struct packed {
    logic mode;
    logic [HALF_W-1:0] cnt;
    logic lclk;
    logic pclk;
    logic sclk_p;
    logic sclk_n;
    logic [NIB_W-1:0] nib;
    logic ctl;
    logic sout_p;
    logic sout_n;
    logic [WORD_W-1:0] hold;
    logic hen;
    logic [SER_BITS-1:0] sh;
    logic [SER_CNT_W-1:0] scnt;
    logic [NIB_W-1:0] plo;
    logic pen;
    pms_ser_state_type rst;
    logic [WORD_W-1:0] rsh;
    logic [SER_CNT_W-1:0] rcnt;
    logic [BYTE_W-1:0] ob;
    logic oe;
    logic ov;
  } pms_end_type;
endpackage

// ==== rtl/pms_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface pms_link_if;
  logic mac_tx_clock;
  logic [pms_pkg::NIB_W-1:0] tx_nibble;
  logic tx_enable_error_combined;
  logic rx_recovered_clock;
  logic [pms_pkg::NIB_W-1:0] rx_nibble;
  logic rx_valid_error_combined;
  logic serial_in_pos;
  logic serial_in_neg;
  logic serial_clk_in_pos;
  logic serial_clk_in_neg;
  logic serial_out_pos;
  logic serial_out_neg;
  logic serial_clk_out_pos;
  logic serial_clk_out_neg;
  modport phy (
    input mac_tx_clock, tx_nibble, tx_enable_error_combined,
    input serial_in_pos, serial_in_neg, serial_clk_in_pos, serial_clk_in_neg,
    output rx_recovered_clock, rx_nibble, rx_valid_error_combined,
    output serial_out_pos, serial_out_neg, serial_clk_out_pos, serial_clk_out_neg
  );
  modport mac (
    output mac_tx_clock, tx_nibble, tx_enable_error_combined,
    output serial_in_pos, serial_in_neg, serial_clk_in_pos, serial_clk_in_neg,
    input rx_recovered_clock, rx_nibble, rx_valid_error_combined,
    input serial_out_pos, serial_out_neg, serial_clk_out_pos, serial_clk_out_neg
  );
endinterface
`default_nettype wire

// ==== rtl/pms_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module pms_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  // Depth must be a power of two: pointers wrap naturally
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic rdy_r, rdy_nxt, push, pop;

  always_comb begin
    push = in_valid && rdy_r;
    pop = out_valid && out_ready;
    wr_nxt = wr_r + (AW+1)'(push);
    rd_nxt = rd_r + (AW+1)'(pop);
    rdy_nxt = (wr_nxt - rd_nxt) != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_r <= '0;
      rd_r <= '0;
      rdy_r <= 1'b0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end

  assign in_ready = rdy_r;
  assign out_valid = wr_r != rd_r;
  assign out_data = mem[rd_r[AW-1:0]];
endmodule
`default_nettype wire

// ==== rtl/pms_phy_end.sv ====
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - MAC drives tx nibble on its clock
// - MAC runs tx clock continuously, 125 MHz; here it runs at clk/2, 100 MHz, and is parked low in serial mode
// - Rx clock rate follows link speed
// - Rx nibble driven on our rx clock
// - MAC merges enable and error, both edges
// - Valid and error merged, both edges
// - Serial mode drives continuous 625 MHz clock; here it runs at clk/2, 100 MHz
// - MAC serial data follows serial clock in
// - Serial data out follows our serial clock
module pms_phy_end
  import pms_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  pms_link_if.phy link,
  input wire logic mode_serial,
  input wire logic [1:0] link_speed,
  input wire logic [BYTE_W-1:0] send_byte,
  input wire logic send_err,
  input wire logic send_valid,
  output logic send_ready,
  output logic [BYTE_W-1:0] recv_byte,
  output logic recv_err,
  output logic recv_valid
);
  // ==========================================================
  // Pin synchronisers and edge detection
  logic [SY_W-1:0] pin_raw, s1_r, s2_r, s3_r;
  logic p_rise, p_fall, s_rise;

  always_comb begin
    pin_raw = {link.mac_tx_clock, link.tx_enable_error_combined, link.tx_nibble,
               link.serial_clk_in_pos, link.serial_in_pos};
    // Edges come from the second stage onward only
    p_rise = s2_r[SY_PCLK] && !s3_r[SY_PCLK];
    p_fall = !s2_r[SY_PCLK] && s3_r[SY_PCLK];
    s_rise = s2_r[SY_SCLK] && !s3_r[SY_SCLK];
  end

  // ==========================================================
  // Outbound buffer
  logic [WORD_W-1:0] f_data;
  logic f_valid, f_pop;

  pms_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_data({send_err, send_byte}),
    .in_valid(send_valid),
    .in_ready(send_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );
  // Sixteen words ride out a slow link clock
  // before the user side stalls

  // ==========================================================
  // Link engine
  pms_end_type s_r, n;
  logic [HALF_W-1:0] half;
  logic tick, rise, fall;

  always_comb begin
    n = s_r;
    n.ov = 1'b0;
    f_pop = 1'b0;
    n.mode = mode_serial;
    // ==========================================================
    // Speed select
    // Rate follows speed only in parallel mode
    half = HALF_SER;
    if (!s_r.mode) begin
      case (link_speed)
        SPD_10: half = HALF_10;
        SPD_100: half = HALF_100;
        default: half = HALF_1000;
      endcase
    end

    // ==========================================================
    // Divider
    // Free running divider; the clock never pauses
    tick = s_r.cnt >= (half - 8'h01);
    n.cnt = tick ? '0 : s_r.cnt + 1'b1;
    n.lclk = tick ? !s_r.lclk : s_r.lclk;
    rise = tick && !s_r.lclk;
    fall = tick && s_r.lclk;

    if (s_r.mode) begin
      // Parallel pins parked so shared terminals stay quiet
      n.pclk = 1'b0;
      n.nib = '0;
      n.ctl = 1'b0;
      n.pen = 1'b0;
      n.hen = 1'b0;
      n.sclk_p = n.lclk;
      n.sclk_n = !n.lclk;

      // ==========================================================
      // Serial send
      // New bit launched on the falling edge, sampled on rising
      if (fall) begin
        if (s_r.scnt > 4'h1) begin
          n.sh = s_r.sh >> 1;
          n.scnt = s_r.scnt - 1'b1;
        end else if (f_valid) begin
          n.sh = {f_data, 1'b1};
          n.scnt = SER_CNT_W'(SER_BITS);
          f_pop = 1'b1;
        end else begin
          n.sh = '0;
          n.scnt = '0;
        end
      end
      n.sout_p = n.sh[0];
      n.sout_n = !n.sh[0];

      // ==========================================================
      // Serial receive
      // Start bit marks a frame; an idle line stays low
      if (s_rise) begin
        case (s_r.rst)
          SR_IDLE: begin
            if (s2_r[SY_SDAT]) begin
              n.rst = SR_SHIFT;
              n.rcnt = '0;
            end
          end
          SR_SHIFT: begin
            n.rsh = {s2_r[SY_SDAT], s_r.rsh[WORD_W-1:1]};
            n.rcnt = s_r.rcnt + 1'b1;
            if (s_r.rcnt == SER_CNT_W'(WORD_W - 1)) begin
              n.rst = SR_IDLE;
              n.ov = 1'b1;
              n.ob = n.rsh[BYTE_W-1:0];
              n.oe = n.rsh[BYTE_W];
            end
          end
          default: n.rst = SR_IDLE;
        endcase
      end
    end else begin
      n.sclk_p = 1'b0;
      n.sclk_n = 1'b0;
      n.sout_p = 1'b0;
      n.sout_n = 1'b0;
      n.sh = '0;
      n.scnt = '0;
      n.rst = SR_IDLE;

      // ==========================================================
      // Parallel send
      n.pclk = n.lclk;
      // Nibble and control change with the clock edge that carries them
      if (rise) begin
        n.hold = f_data;
        n.hen = f_valid;
        f_pop = f_valid;
        n.nib = f_valid ? f_data[NIB_W-1:0] : '0;
        n.ctl = f_valid;
      end else if (fall) begin
        n.nib = s_r.hen ? s_r.hold[BYTE_W-1:NIB_W] : '0;
        n.ctl = s_r.hen ^ (s_r.hen && s_r.hold[BYTE_W]);
      end

      // ==========================================================
      // Parallel capture
      // Clock and data share sync depth, so they stay aligned
      if (p_rise) begin
        n.plo = s2_r[SY_NIB +: NIB_W];
        n.pen = s2_r[SY_PCTL];
      end
      // Error without enable is a false carrier; it yields no byte
      if (p_fall && s_r.pen) begin
        n.ov = 1'b1;
        n.ob = {s2_r[SY_NIB +: NIB_W], s_r.plo};
        n.oe = s2_r[SY_PCTL] ^ s_r.pen;
      end
    end
  end

  // Third stage only feeds edge detection, never data
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      s_r <= '0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      s_r <= n;
    end
  end

  // ==========================================================
  // Pin and user outputs, all straight from flops
  assign link.rx_recovered_clock = s_r.pclk;
  assign link.rx_nibble = s_r.nib;
  assign link.rx_valid_error_combined = s_r.ctl;
  assign link.serial_clk_out_pos = s_r.sclk_p;
  assign link.serial_clk_out_neg = s_r.sclk_n;
  assign link.serial_out_pos = s_r.sout_p;
  assign link.serial_out_neg = s_r.sout_n;
  assign recv_byte = s_r.ob;
  assign recv_err = s_r.oe;
  assign recv_valid = s_r.ov;
endmodule
`default_nettype wire

// ==== rtl/pms_mac_end.sv ====
`timescale 1ns/100ps
`default_nettype none
module pms_mac_end
  import pms_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  pms_link_if.mac link,
  input wire logic mode_serial,
  input wire logic [BYTE_W-1:0] send_byte,
  input wire logic send_err,
  input wire logic send_valid,
  output logic send_ready,
  output logic [BYTE_W-1:0] recv_byte,
  output logic recv_err,
  output logic recv_valid
);
  // ==========================================================
  // Pin synchronisers and edge detection
  logic [SY_W-1:0] pin_raw, s1_r, s2_r, s3_r;
  logic p_rise, p_fall, s_rise;

  always_comb begin
    pin_raw = {link.rx_recovered_clock, link.rx_valid_error_combined, link.rx_nibble,
               link.serial_clk_out_pos, link.serial_out_pos};
    p_rise = s2_r[SY_PCLK] && !s3_r[SY_PCLK];
    p_fall = !s2_r[SY_PCLK] && s3_r[SY_PCLK];
    s_rise = s2_r[SY_SCLK] && !s3_r[SY_SCLK];
  end

  // ==========================================================
  // Outbound buffer
  logic [WORD_W-1:0] f_data;
  logic f_valid, f_pop;

  pms_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_data({send_err, send_byte}),
    .in_valid(send_valid),
    .in_ready(send_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );

  // ==========================================================
  // Link engine
  pms_end_type s_r, n;
  logic [HALF_W-1:0] half;
  logic tick, rise, fall;

  always_comb begin
    n = s_r;
    n.ov = 1'b0;
    f_pop = 1'b0;
    n.mode = mode_serial;
    half = s_r.mode ? HALF_SER : HALF_TX;
    tick = s_r.cnt >= (half - 8'h01);
    n.cnt = tick ? '0 : s_r.cnt + 1'b1;
    n.lclk = tick ? !s_r.lclk : s_r.lclk;
    rise = tick && !s_r.lclk;
    fall = tick && s_r.lclk;

    if (s_r.mode) begin
      n.pclk = 1'b0;
      n.nib = '0;
      n.ctl = 1'b0;
      n.pen = 1'b0;
      n.hen = 1'b0;
      n.sclk_p = n.lclk;
      n.sclk_n = !n.lclk;
      if (fall) begin
        if (s_r.scnt > 4'h1) begin
          n.sh = s_r.sh >> 1;
          n.scnt = s_r.scnt - 1'b1;
        end else if (f_valid) begin
          n.sh = {f_data, 1'b1};
          n.scnt = SER_CNT_W'(SER_BITS);
          f_pop = 1'b1;
        end else begin
          n.sh = '0;
          n.scnt = '0;
        end
      end
      n.sout_p = n.sh[0];
      n.sout_n = !n.sh[0];
      if (s_rise) begin
        case (s_r.rst)
          SR_IDLE: begin
            if (s2_r[SY_SDAT]) begin
              n.rst = SR_SHIFT;
              n.rcnt = '0;
            end
          end
          SR_SHIFT: begin
            n.rsh = {s2_r[SY_SDAT], s_r.rsh[WORD_W-1:1]};
            n.rcnt = s_r.rcnt + 1'b1;
            if (s_r.rcnt == SER_CNT_W'(WORD_W - 1)) begin
              n.rst = SR_IDLE;
              n.ov = 1'b1;
              n.ob = n.rsh[BYTE_W-1:0];
              n.oe = n.rsh[BYTE_W];
            end
          end
          default: n.rst = SR_IDLE;
        endcase
      end
    end else begin
      n.sclk_p = 1'b0;
      n.sclk_n = 1'b0;
      n.sout_p = 1'b0;
      n.sout_n = 1'b0;
      n.sh = '0;
      n.scnt = '0;
      n.rst = SR_IDLE;
      n.pclk = n.lclk;
      if (rise) begin
        n.hold = f_data;
        n.hen = f_valid;
        f_pop = f_valid;
        n.nib = f_valid ? f_data[NIB_W-1:0] : '0;
        n.ctl = f_valid;
      end else if (fall) begin
        n.nib = s_r.hen ? s_r.hold[BYTE_W-1:NIB_W] : '0;
        n.ctl = s_r.hen ^ (s_r.hen && s_r.hold[BYTE_W]);
      end
      // Speed only changes the rx clock rate, so edges drive capture
      if (p_rise) begin
        n.plo = s2_r[SY_NIB +: NIB_W];
        n.pen = s2_r[SY_PCTL];
      end
      if (p_fall && s_r.pen) begin
        n.ov = 1'b1;
        n.ob = {s2_r[SY_NIB +: NIB_W], s_r.plo};
        n.oe = s2_r[SY_PCTL] ^ s_r.pen;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      s_r <= '0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      s_r <= n;
    end
  end

  // ==========================================================
  // Pin and user outputs, all straight from flops
  assign link.mac_tx_clock = s_r.pclk;
  assign link.tx_nibble = s_r.nib;
  assign link.tx_enable_error_combined = s_r.ctl;
  assign link.serial_clk_in_pos = s_r.sclk_p;
  assign link.serial_clk_in_neg = s_r.sclk_n;
  assign link.serial_in_pos = s_r.sout_p;
  assign link.serial_in_neg = s_r.sout_n;
  assign recv_byte = s_r.ob;
  assign recv_err = s_r.oe;
  assign recv_valid = s_r.ov;
endmodule
`default_nettype wire

// ==== tb/pms_link_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module pms_link_properties
  import pms_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic mac_tx_clock,
  input wire logic [NIB_W-1:0] tx_nibble,
  input wire logic serial_clk_in_pos,
  input wire logic rx_recovered_clock,
  input wire logic [NIB_W-1:0] rx_nibble,
  input wire logic rx_valid_error_combined,
  input wire logic serial_out_pos,
  input wire logic serial_out_neg,
  input wire logic serial_clk_out_pos,
  input wire logic serial_clk_out_neg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ==========================================================
  // Link clock edges
  sequence rx_rise_s;
    $rose(rx_recovered_clock);
  endsequence
  sequence rx_fall_s;
    $fell(rx_recovered_clock);
  endsequence
  // ==========================================================
  // Checks
  mode_excl_a: assert property (!(rx_recovered_clock && serial_clk_out_pos) && !(mac_tx_clock && serial_clk_in_pos))
    else $error("both link modes active");
  txclk_half_a: assert property ($rose(mac_tx_clock) |=> $fell(mac_tx_clock))
    else $error("tx clock high too long");
  rxclk_half_a: assert property (rx_rise_s |-> ##[1:40] rx_fall_s)
    else $error("rx clock half period too long");
  serclk_half_a: assert property ($rose(serial_clk_out_pos) |=> $fell(serial_clk_out_pos))
    else $error("serial clock high too long");
  ser_pair_a: assert property (!(serial_clk_out_pos && serial_clk_out_neg) && !(serial_out_pos && serial_out_neg))
    else $error("serial pair not complementary");
  serdat_fall_a: assert property ($changed(serial_out_pos) |-> $fell(serial_clk_out_pos))
    else $error("serial data moved off falling edge");
  rxnib_edge_a: assert property ($changed(rx_nibble) |-> $changed(rx_recovered_clock))
    else $error("rx nibble moved off clock edge");
  txnib_edge_a: assert property ($changed(tx_nibble) |-> $changed(mac_tx_clock))
    else $error("tx nibble moved off clock edge");
  rxctl_idle_a: assert property ((rx_rise_s and rx_valid_error_combined == 1'h0) |-> rx_nibble == 4'h0)
    else $error("data without valid on rising edge");
endmodule
`default_nettype wire

// ==== tb/phy_mac_side_rgmii_sgmii_port_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module phy_mac_side_rgmii_sgmii_port_test
  import pms_pkg::*;
;
  typedef struct packed {logic mode; logic [1:0] spd; logic [WORD_W-1:0] w;} pms_row_type;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic mode_serial = 1'h0;
  logic [1:0] link_speed = SPD_1000;
  logic [BYTE_W-1:0] p_sb = 8'h00, m_sb = 8'h00, p_rb, m_rb;
  logic p_se = 1'h0, p_sv = 1'h0, m_se = 1'h0, m_sv = 1'h0;
  logic p_sr, m_sr, p_rv, m_rv, p_re, m_re;
  logic [WORD_W-1:0] p_q[$], m_q[$], w_q[$];
  logic [WORD_W-1:0] sf = 9'h000;
  logic pc_r = 1'h0, lc_r = 1'h0, sc_r = 1'h0;
  logic [NIB_W-1:0] lo_r = 4'h0;
  int sn = 0, n_fail = 0, checked = 0, acc = 0, full = 0;
  pms_row_type rows [6] = '{'{1'h0, SPD_1000, 9'h0A5}, '{1'h0, SPD_100, 9'h13C}, '{1'h0, SPD_10, 9'h081},
    '{1'h0, 2'h3, 9'h1FF}, '{1'h1, SPD_1000, 9'h16E}, '{1'h1, SPD_10, 9'h000}};
  // ==========================================================
  // Both ends face each other
  pms_link_if pms_link_if_inst ();
  wire logic rxc = pms_link_if_inst.rx_recovered_clock;
  wire logic rxl = pms_link_if_inst.rx_valid_error_combined;
  wire logic [NIB_W-1:0] rxn = pms_link_if_inst.rx_nibble;
  wire logic soc = pms_link_if_inst.serial_clk_out_pos;
  wire logic sod = pms_link_if_inst.serial_out_pos;
  pms_phy_end pms_phy_end_inst (.clk(clk), .reset(reset), .link(pms_link_if_inst), .mode_serial(mode_serial),
    .link_speed(link_speed), .send_byte(p_sb), .send_err(p_se), .send_valid(p_sv), .send_ready(p_sr),
    .recv_byte(p_rb), .recv_err(p_re), .recv_valid(p_rv));
  pms_mac_end pms_mac_end_inst (.clk(clk), .reset(reset), .link(pms_link_if_inst), .mode_serial(mode_serial),
    .send_byte(m_sb), .send_err(m_se), .send_valid(m_sv), .send_ready(m_sr),
    .recv_byte(m_rb), .recv_err(m_re), .recv_valid(m_rv));
  pms_link_properties pms_link_properties_inst (.clk(clk), .reset(reset),
    .mac_tx_clock(pms_link_if_inst.mac_tx_clock), .tx_nibble(pms_link_if_inst.tx_nibble),
    .serial_clk_in_pos(pms_link_if_inst.serial_clk_in_pos), .rx_recovered_clock(rxc), .rx_nibble(rxn),
    .rx_valid_error_combined(rxl), .serial_out_pos(sod), .serial_out_neg(pms_link_if_inst.serial_out_neg),
    .serial_clk_out_pos(soc), .serial_clk_out_neg(pms_link_if_inst.serial_clk_out_neg));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ==========================================================
  // Monitors: user pulses and phy-to-mac wire decoding
  always @(posedge clk) begin
    if (p_rv) p_q.push_back({p_re, p_rb});
    if (m_rv) m_q.push_back({m_re, m_rb});
    pc_r <= rxc;
    sc_r <= soc;
    if (rxc && !pc_r) begin
      lo_r <= rxn;
      lc_r <= rxl;
    end
    if (!rxc && pc_r && lc_r) w_q.push_back({rxl, rxn, lo_r});
    if (soc && !sc_r) begin
      if (sn == 0) sn = int'(sod);
      else begin
        sf = {sod, sf[WORD_W-1:1]};
        sn++;
        if (sn == SER_BITS) begin
          w_q.push_back(sf);
          sn = 0;
        end
      end
    end
  end
  // ==========================================================
  // Tasks
  task chk_w(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] e);
    checked++;
    if (a !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task chk_b(input logic a, input logic e);
    checked++;
    if (a !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task wait_q(input int np, input int nm);
    int k;
    for (k = 0; k < 4000 && (p_q.size() < np || m_q.size() < nm || w_q.size() < nm); k++) @(posedge clk);
    chk_b(k < 4000, 1'h1);
  endtask
  task run_row(input int i);
    mode_serial <= rows[i].mode;
    link_speed <= rows[i].spd;
    // Idle gap lets a mode switch settle before traffic
    repeat (100) @(posedge clk);
    p_q.delete();
    m_q.delete();
    w_q.delete();
    p_sv <= 1'h1;
    p_sb <= rows[i].w[7:0];
    p_se <= rows[i].w[8];
    m_sv <= 1'h1;
    m_sb <= ~rows[i].w[7:0];
    m_se <= rows[i].w[8];
    @(posedge clk);
    p_sv <= 1'h0;
    m_sv <= 1'h0;
    wait_q(1, 1);
    chk_w(m_q[0], rows[i].w);
    chk_w(p_q[0], {rows[i].w[8], ~rows[i].w[7:0]});
    chk_w(w_q[0], rows[i].mode ? rows[i].w : {~rows[i].w[8], rows[i].w[7:0]});
  endtask
  task stop_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    chk_b(p_sr, 1'h0);
    chk_b(m_sr, 1'h0);
    chk_b(rxc, 1'h0);
    reset <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk_b(p_sr, 1'h1);
    chk_b(m_sr, 1'h1);
    for (int i = 0; i < 6; i++) run_row(i);
    // Slowest speed so the buffer fills before it drains
    mode_serial <= 1'h0;
    link_speed <= SPD_10;
    repeat (100) @(posedge clk);
    m_q.delete();
    w_q.delete();
    p_sb <= 8'h10;
    p_se <= 1'h0;
    p_sv <= 1'h1;
    repeat (24) begin
      @(posedge clk);
      if (p_sr === 1'h1) acc++;
      else full++;
      p_sb <= 8'h10 + 8'(acc);
    end
    p_sv <= 1'h0;
    chk_b(full > 0 && acc >= FIFO_DEPTH && acc <= FIFO_DEPTH + 2, 1'h1);
    wait_q(0, acc);
    for (int j = 0; j < acc; j++) chk_w(m_q[j], {1'h0, 8'h10 + 8'(j)});
    chk_b(p_sr, 1'h1);
    // Reset in mid-run, then traffic must recover
    @(posedge clk);
    reset <= 1'h1;
    repeat (3) @(posedge clk);
    #1;
    chk_b(p_sr, 1'h0);
    chk_b(rxc, 1'h0);
    @(posedge clk);
    reset <= 1'h0;
    run_row(4);
    run_row(1);
    stop_test();
  end
  initial begin
    #80000;
    n_fail++;
    $display("unexpected at %0t: got %h expected %h", $time, 1'h1, 1'h0);
    stop_test();
  end
endmodule
`default_nettype wire
